/* File: hw/oad_defines.svh */
/*
  Constants of the operand address decoder: register numbers, steps, reset value.
  Assumes a 16-entry working register file of 16-bit words.
*/
`ifndef OAD_DEFINES_SVH
`define OAD_DEFINES_SVH

// ----------------------------------------
// Working register numbers
// ----------------------------------------
`define OAD_REG_XA 4'h8
`define OAD_REG_XB 4'h9
`define OAD_REG_YA 4'ha
`define OAD_REG_YB 4'hb
`define OAD_REG_FP 4'he
`define OAD_REG_SP 4'hf

// ----------------------------------------
// Steps and reset values
// ----------------------------------------
`define OAD_WORD_STEP 16'h0002
`define OAD_MAC_STEP2 16'h0002
`define OAD_MAC_STEP4 16'h0004
`define OAD_MAC_STEP6 16'h0006
`define OAD_REG_RST 16'h0000
`define OAD_LIT8_MSB 7
`define OAD_INT_DIS_MSB 13

`endif

/* File: hw/oad_pkg.sv */
/*
  Types of the operand address decoder: instruction classes and addressing modes.
  Assumes nothing of its surroundings.
*/
package oad_pkg;

  // ----------------------------------------
  // Instruction classes
  // ----------------------------------------
  typedef enum logic [3:0] {
    OAD_NO_OPERATION_OP = 4'h0,
    OAD_REGISTER_MOVE_OP = 4'h1,
    OAD_ACCUMULATOR_OP = 4'h2,
    OAD_GENERIC_OP = 4'h3,
    OAD_BRANCH_OP = 4'h4,
    OAD_INTERRUPT_DISABLE_OP = 4'h5,
    OAD_FRAME_UNLINK_OP = 4'h6,
    OAD_MULTIPLY_OP = 4'h7,
    OAD_MULTIPLY_SUBTRACT_OP = 4'h8,
    OAD_EUCLID_DISTANCE_ACC_OP = 4'h9,
    OAD_PREFETCH_STORE_ACC_OP = 4'ha
  } oad_op_t;

  // ----------------------------------------
  // Addressing modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    OAD_AM_DIRECT = 3'h0,
    OAD_AM_IND = 3'h1,
    OAD_AM_POST = 3'h2,
    OAD_AM_PRE = 3'h3,
    OAD_AM_INDEXED = 3'h4,
    OAD_AM_LIT_OFS = 3'h5,
    OAD_AM_LIT8 = 3'h6,
    OAD_AM_LIT16 = 3'h7
  } oad_mode_t;

  typedef enum logic [2:0] {
    OAD_MAC_IND = 3'h0,
    OAD_MAC_POST2 = 3'h1,
    OAD_MAC_POST4 = 3'h2,
    OAD_MAC_POST6 = 3'h3,
    OAD_MAC_INDEXED = 3'h4
  } oad_mac_mode_t;

endpackage

/* File: hw/oad_ea_unit.sv */
/*
  Effective address unit for one operand of an ordinary instruction.
  Assumes the caller supplies the pointer, offset register and literal values.
*/
`timescale 1ns/1ps
`include "oad_defines.svh"
module oad_ea_unit import oad_pkg::*; (
  input oad_mode_t mode,
  input logic [15:0] base,
  input logic [15:0] ofs,
  input logic [15:0] lit,
  input logic [15:0] step,
  output logic [15:0] ea,
  output logic [15:0] ptr_nxt,
  output logic ptr_we,
  output logic is_reg,
  output logic is_lit
);

  always_comb begin
    ea = base;
    ptr_nxt = base;
    ptr_we = 1'b0;
    is_reg = 1'b0;
    is_lit = 1'b0;
    case (mode)
      OAD_AM_DIRECT: is_reg = 1'b1;
      OAD_AM_IND: ea = base;
      OAD_AM_POST: begin
        // Access uses the old address, pointer moves afterwards
        ptr_nxt = base + step;
        ptr_we = 1'b1;
      end
      OAD_AM_PRE: begin
        ptr_nxt = base + step;
        ea = base + step;
        ptr_we = 1'b1;
      end
      OAD_AM_INDEXED: ea = base + ofs;
      OAD_AM_LIT_OFS: ea = base + lit;
      OAD_AM_LIT8: begin
        ea = {8'h00, lit[`OAD_LIT8_MSB:0]};
        is_lit = 1'b1;
      end
      OAD_AM_LIT16: begin
        ea = lit;
        is_lit = 1'b1;
      end
      default: ea = base;
    endcase
  end

endmodule

/* File: hw/oad_mac_route.sv */
/*
  Prefetch pointer routing of dual-source multiply instructions to X and Y.
  Assumes bank holds pointer registers 8 to 11 in order; side 0 is X, 1 is Y.
*/
`timescale 1ns/1ps
`include "oad_defines.svh"
module oad_mac_route import oad_pkg::*; (
  input logic [1:0][3:0] ptr_reg,
  input logic [1:0][2:0] mode,
  input logic [3:0][15:0] bank,
  input logic [15:0] ofs,
  output wire [1:0][15:0] addr,
  output wire [1:0][15:0] nxt,
  output wire [1:0] we,
  output wire [1:0] ok
);

  for (genvar s = 0; s < 2; s++) begin : g_side
    localparam logic [3:0] REG_A = (s == 0) ? `OAD_REG_XA : `OAD_REG_YA;
    logic in_set;
    logic sel_b;
    logic [15:0] base;
    logic [15:0] addr_s;
    logic [15:0] nxt_s;
    logic we_s;
    logic ok_s;

    // Side 0 only sees 8/9, side 1 only 10/11
    assign in_set = ptr_reg[s][3:1] == REG_A[3:1];
    assign sel_b = ptr_reg[s][0];
    assign base = sel_b ? bank[2*s+1] : bank[2*s];

    always_comb begin
      addr_s = base;
      nxt_s = base;
      we_s = 1'b0;
      ok_s = in_set;
      case (mode[s])
        OAD_MAC_IND: addr_s = base;
        OAD_MAC_POST2: begin
          nxt_s = base + `OAD_MAC_STEP2;
          we_s = 1'b1;
        end
        OAD_MAC_POST4: begin
          nxt_s = base + `OAD_MAC_STEP4;
          we_s = 1'b1;
        end
        OAD_MAC_POST6: begin
          nxt_s = base + `OAD_MAC_STEP6;
          we_s = 1'b1;
        end
        OAD_MAC_INDEXED: begin
          addr_s = base + ofs;
          ok_s = in_set & sel_b;
        end
        default: ok_s = 1'b0;
      endcase
    end

    assign addr[s] = addr_s;
    assign nxt[s] = nxt_s;
    assign we[s] = we_s;
    assign ok[s] = ok_s;
  end

endmodule

/* File: hw/oad_operand_decode.sv */
/*
  Operand addressing decoder: checks each instruction's addressing modes,
  forms effective addresses, steps pointers and routes prefetches to X or Y.
  Assumes one instruction offered per cycle with INSTR_VALID, all inputs on
  REF_CLK; results appear one cycle later.
*/
//
// Behaviour
// - Move and accumulator classes accept base plus offset register mode
// - Move source and destination may use different modes together
// - One 4-bit offset register field serves both move operands
// - Move modes: direct, indirect, post, pre, indexed, offset, literals (source only); accumulator: indirect, post, pre, indexed, offset
// - Each class permits only its own subset of modes; others are illegal
// - Multiply class uses a reduced mode set only
// - Multiply prefetch pointers come only from registers eight to eleven
// - Pointers eight and nine read through the X address path
// - Pointers ten and eleven read through the Y address path
// - Multiply indexed mode only on registers nine and eleven
// - Multiply modes: indirect, indexed, post-modify by two, four or six
// - Branch displacement is the 16-bit signed literal of the instruction
// - Interrupt-disable count is the 14-bit unsigned literal field
// - Frame unlink has implied operands, no operand field
// - No-operation decodes with no operands at all
`timescale 1ns/1ps
`include "oad_defines.svh"
module oad_operand_decode import oad_pkg::*; (
  input logic REF_CLK,
  input logic RESET_N,
  input logic INSTR_VALID,
  input oad_op_t INSTR_OP,
  input oad_mode_t SRC_MODE,
  input logic [3:0] SRC_REG,
  input oad_mode_t DST_MODE,
  input logic [3:0] DST_REG,
  input logic [3:0] OFFSET_REGISTER_FIELD,
  input logic [3:0] MOD_STEP,
  input logic [15:0] LIT_FIELD,
  input logic [3:0] X_PREF_REG,
  input oad_mac_mode_t X_PREF_MODE,
  input logic [3:0] Y_PREF_REG,
  input oad_mac_mode_t Y_PREF_MODE,
  input logic WREG_WE,
  input logic [3:0] WREG_SEL,
  input logic [15:0] WREG_WDATA,
  output logic [15:0] WREG_RDATA,
  output logic DEC_DONE,
  output logic DEC_ILLEGAL,
  output logic [15:0] SRC_EA,
  output logic SRC_IS_REG,
  output logic SRC_IS_LIT,
  output logic [15:0] DST_EA,
  output logic DST_IS_REG,
  output logic X_RD_EN,
  output logic [15:0] X_RD_ADDR,
  output logic Y_RD_EN,
  output logic [15:0] Y_RD_ADDR,
  output logic BRANCH_EN,
  output logic [15:0] BRANCH_DISP,
  output logic INT_DIS_EN,
  output logic [13:0] INT_DIS_COUNT,
  output logic IMPLIED_OP,
  output logic NO_OPERAND
);

  // ----------------------------------------
  // Working registers and operand values
  // ----------------------------------------
  logic [15:0] wreg_r [16];
  logic [15:0] wreg_nxt [16];
  logic [15:0] src_base;
  logic [15:0] dst_base;
  logic [15:0] ofs_val;
  logic [15:0] step_ext;
  logic [15:0] fp_val;
  logic [15:0] unlink_addr;
  logic [3:0][15:0] mac_bank;

  assign src_base = wreg_r[SRC_REG];
  assign dst_base = wreg_r[DST_REG];
  // Shared by source and destination of a move
  assign ofs_val = wreg_r[OFFSET_REGISTER_FIELD];
  assign step_ext = {{12{MOD_STEP[3]}}, MOD_STEP};
  assign fp_val = wreg_r[`OAD_REG_FP];
  assign unlink_addr = fp_val - `OAD_WORD_STEP;
  assign mac_bank = {wreg_r[11], wreg_r[10], wreg_r[9], wreg_r[8]};

  // ----------------------------------------
  // Address units
  // ----------------------------------------
  logic [15:0] src_ea;
  logic [15:0] src_ptr;
  logic src_we;
  logic src_isreg;
  logic src_islit;
  logic [15:0] dst_ea;
  logic [15:0] dst_ptr;
  logic dst_we;
  logic dst_isreg;
  logic dst_islit;
  logic [1:0][15:0] mac_addr;
  logic [1:0][15:0] mac_nxt;
  logic [1:0] mac_we;
  logic [1:0] mac_ok;

  // Separate units so source and destination modes differ freely
  oad_ea_unit u_src (
    .mode(SRC_MODE),
    .base(src_base),
    .ofs(ofs_val),
    .lit(LIT_FIELD),
    .step(step_ext),
    .ea(src_ea),
    .ptr_nxt(src_ptr),
    .ptr_we(src_we),
    .is_reg(src_isreg),
    .is_lit(src_islit)
  );

  oad_ea_unit u_dst (
    .mode(DST_MODE),
    .base(dst_base),
    .ofs(ofs_val),
    .lit(LIT_FIELD),
    .step(step_ext),
    .ea(dst_ea),
    .ptr_nxt(dst_ptr),
    .ptr_we(dst_we),
    .is_reg(dst_isreg),
    .is_lit(dst_islit)
  );

  oad_mac_route u_mac (
    .ptr_reg({Y_PREF_REG, X_PREF_REG}),
    .mode({Y_PREF_MODE, X_PREF_MODE}),
    .bank(mac_bank),
    .ofs(ofs_val),
    .addr(mac_addr),
    .nxt(mac_nxt),
    .we(mac_we),
    .ok(mac_ok)
  );

  // ----------------------------------------
  // Mode permission per class
  // ----------------------------------------
  logic uses_src;
  logic uses_dst;
  logic is_mac;
  logic legal;
  logic accept;

  always_comb begin
    uses_src = 1'b0;
    uses_dst = 1'b0;
    is_mac = 1'b0;
    legal = 1'b1;
    case (INSTR_OP)
      OAD_REGISTER_MOVE_OP: begin
        uses_src = 1'b1;
        uses_dst = 1'b1;
        legal = DST_MODE != OAD_AM_LIT8 && DST_MODE != OAD_AM_LIT16;
      end
      OAD_ACCUMULATOR_OP: begin
        uses_src = 1'b1;
        legal = SRC_MODE inside {OAD_AM_IND, OAD_AM_POST, OAD_AM_PRE,
          OAD_AM_INDEXED, OAD_AM_LIT_OFS};
      end
      OAD_GENERIC_OP: begin
        uses_src = 1'b1;
        uses_dst = 1'b1;
        legal = SRC_MODE <= OAD_AM_PRE && DST_MODE <= OAD_AM_PRE;
      end
      OAD_MULTIPLY_OP, OAD_MULTIPLY_SUBTRACT_OP, OAD_EUCLID_DISTANCE_ACC_OP,
      OAD_PREFETCH_STORE_ACC_OP: begin
        is_mac = 1'b1;
        legal = &mac_ok;
      end
      OAD_BRANCH_OP, OAD_INTERRUPT_DISABLE_OP, OAD_FRAME_UNLINK_OP,
      OAD_NO_OPERATION_OP: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end

  assign accept = INSTR_VALID && legal;

  // ----------------------------------------
  // Pointer write-back
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      wreg_nxt[i] = wreg_r[i];
    end
    if (WREG_WE) begin
      wreg_nxt[WREG_SEL] = WREG_WDATA;
    end
    if (accept) begin
      if (uses_src && src_we) begin
        wreg_nxt[SRC_REG] = src_ptr;
      end
      if (uses_dst && dst_we) begin
        wreg_nxt[DST_REG] = dst_ptr;
      end
      if (is_mac && mac_we[0]) begin
        wreg_nxt[X_PREF_REG] = mac_nxt[0];
      end
      if (is_mac && mac_we[1]) begin
        wreg_nxt[Y_PREF_REG] = mac_nxt[1];
      end
      if (INSTR_OP == OAD_FRAME_UNLINK_OP) begin
        wreg_nxt[`OAD_REG_SP] = unlink_addr;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < 16; i++) begin
        wreg_r[i] <= `OAD_REG_RST;
      end
    end else begin
      for (int i = 0; i < 16; i++) begin
        wreg_r[i] <= wreg_nxt[i];
      end
    end
  end

  // ----------------------------------------
  // Decode results
  // ----------------------------------------
  logic [15:0] rdata_nxt;
  logic done_nxt;
  logic ill_nxt;
  logic [15:0] src_ea_nxt;
  logic src_reg_nxt;
  logic src_lit_nxt;
  logic [15:0] dst_ea_nxt;
  logic dst_reg_nxt;
  logic x_en_nxt;
  logic [15:0] x_addr_nxt;
  logic y_en_nxt;
  logic [15:0] y_addr_nxt;
  logic br_en_nxt;
  logic int_dis_en_nxt;
  logic impl_nxt;
  logic none_nxt;

  always_comb begin
    rdata_nxt = wreg_r[WREG_SEL];
    done_nxt = INSTR_VALID;
    ill_nxt = INSTR_VALID && !legal;
    src_ea_nxt = (accept && uses_src) ? src_ea : 16'h0000;
    src_reg_nxt = accept && uses_src && src_isreg;
    src_lit_nxt = accept && uses_src && src_islit;
    dst_ea_nxt = (accept && uses_dst) ? dst_ea : 16'h0000;
    dst_reg_nxt = accept && uses_dst && dst_isreg;
    // X path gets 8/9 and the implied unlink read; Y path gets 10/11
    x_en_nxt = accept && (is_mac || INSTR_OP == OAD_FRAME_UNLINK_OP);
    x_addr_nxt = is_mac ? mac_addr[0] : unlink_addr;
    y_en_nxt = accept && is_mac;
    y_addr_nxt = mac_addr[1];
    br_en_nxt = accept && INSTR_OP == OAD_BRANCH_OP;
    int_dis_en_nxt = accept && INSTR_OP == OAD_INTERRUPT_DISABLE_OP;
    impl_nxt = accept && INSTR_OP == OAD_FRAME_UNLINK_OP;
    none_nxt = accept && INSTR_OP == OAD_NO_OPERATION_OP;
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WREG_RDATA <= 16'h0000;
      DEC_DONE <= 1'b0;
      DEC_ILLEGAL <= 1'b0;
      SRC_EA <= 16'h0000;
      SRC_IS_REG <= 1'b0;
      SRC_IS_LIT <= 1'b0;
      DST_EA <= 16'h0000;
      DST_IS_REG <= 1'b0;
      X_RD_EN <= 1'b0;
      X_RD_ADDR <= 16'h0000;
      Y_RD_EN <= 1'b0;
      Y_RD_ADDR <= 16'h0000;
      BRANCH_EN <= 1'b0;
      BRANCH_DISP <= 16'h0000;
      INT_DIS_EN <= 1'b0;
      INT_DIS_COUNT <= 14'h0000;
      IMPLIED_OP <= 1'b0;
      NO_OPERAND <= 1'b0;
    end else begin
      WREG_RDATA <= rdata_nxt;
      DEC_DONE <= done_nxt;
      DEC_ILLEGAL <= ill_nxt;
      SRC_EA <= src_ea_nxt;
      SRC_IS_REG <= src_reg_nxt;
      SRC_IS_LIT <= src_lit_nxt;
      DST_EA <= dst_ea_nxt;
      DST_IS_REG <= dst_reg_nxt;
      X_RD_EN <= x_en_nxt;
      X_RD_ADDR <= x_addr_nxt;
      Y_RD_EN <= y_en_nxt;
      Y_RD_ADDR <= y_addr_nxt;
      BRANCH_EN <= br_en_nxt;
      BRANCH_DISP <= LIT_FIELD;
      INT_DIS_EN <= int_dis_en_nxt;
      INT_DIS_COUNT <= LIT_FIELD[`OAD_INT_DIS_MSB:0];
      IMPLIED_OP <= impl_nxt;
      NO_OPERAND <= none_nxt;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  chk_acc_indexed: assert property (
    INSTR_VALID && INSTR_OP == OAD_ACCUMULATOR_OP && SRC_MODE == OAD_AM_INDEXED
    |=> !DEC_ILLEGAL && SRC_EA == $past(src_base) + $past(ofs_val))
    else $error("indexed accumulator operand mis-formed");

  chk_shared_offset: assert property (
    INSTR_VALID && INSTR_OP == OAD_REGISTER_MOVE_OP
    && SRC_MODE == OAD_AM_INDEXED && DST_MODE == OAD_AM_INDEXED
    |=> SRC_EA - DST_EA == $past(src_base) - $past(dst_base))
    else $error("move operands did not share the offset register");

  chk_move_lit_dst: assert property (
    INSTR_VALID && INSTR_OP == OAD_REGISTER_MOVE_OP && DST_MODE == OAD_AM_LIT16
    |=> DEC_ILLEGAL && !SRC_IS_LIT)
    else $error("literal move destination accepted");

  chk_generic_subset: assert property (
    INSTR_VALID && INSTR_OP == OAD_GENERIC_OP && SRC_MODE == OAD_AM_INDEXED
    |=> DEC_ILLEGAL ##1 !DEC_ILLEGAL || $past(INSTR_VALID))
    else $error("generic class accepted indexed mode");

  chk_mac_ptr_range: assert property (
    INSTR_VALID && is_mac && X_PREF_REG[3:1] != `OAD_REG_XA >> 1
    |=> DEC_ILLEGAL && !X_RD_EN && !Y_RD_EN)
    else $error("prefetch pointer outside eight to eleven accepted");

  chk_x_route: assert property (
    INSTR_VALID && INSTR_OP == OAD_MULTIPLY_OP && X_PREF_REG == `OAD_REG_XA
    && X_PREF_MODE == OAD_MAC_IND && Y_PREF_REG == `OAD_REG_YA
    && Y_PREF_MODE == OAD_MAC_IND
    |=> X_RD_EN && X_RD_ADDR == $past(mac_bank[0]) && Y_RD_ADDR == $past(mac_bank[2]))
    else $error("pointer not routed to its own address path");

  chk_y_indexed: assert property (
    INSTR_VALID && INSTR_OP == OAD_EUCLID_DISTANCE_ACC_OP
    && X_PREF_REG == `OAD_REG_XB && X_PREF_MODE == OAD_MAC_IND
    && Y_PREF_REG == `OAD_REG_YB && Y_PREF_MODE == OAD_MAC_INDEXED
    |=> Y_RD_EN && Y_RD_ADDR == $past(mac_bank[3]) + $past(ofs_val))
    else $error("indexed Y prefetch mis-formed");

  chk_mac_idx_only_b: assert property (
    INSTR_VALID && is_mac && X_PREF_REG == `OAD_REG_XA
    && X_PREF_MODE == OAD_MAC_INDEXED
    |=> DEC_ILLEGAL)
    else $error("indexed prefetch accepted on register eight");

  chk_mac_post6: assert property (
    INSTR_VALID && INSTR_OP == OAD_MULTIPLY_OP && !WREG_WE
    && X_PREF_REG == `OAD_REG_XB && X_PREF_MODE == OAD_MAC_POST6
    && Y_PREF_REG == `OAD_REG_YA && Y_PREF_MODE == OAD_MAC_IND
    |=> X_RD_ADDR == $past(mac_bank[1])
    && mac_bank[1] == $past(mac_bank[1]) + `OAD_MAC_STEP6)
    else $error("post-modify by six wrong");

  chk_branch_disp: assert property (
    INSTR_VALID && INSTR_OP == OAD_BRANCH_OP
    |=> BRANCH_EN && BRANCH_DISP == $past(LIT_FIELD) ##1 !BRANCH_EN || DEC_DONE)
    else $error("branch displacement wrong");

  chk_unlink_implied: assert property (
    INSTR_VALID && INSTR_OP == OAD_FRAME_UNLINK_OP
    |=> IMPLIED_OP && X_RD_ADDR == $past(fp_val) - `OAD_WORD_STEP)
    else $error("implied unlink operand wrong");

  chk_nop_none: assert property (
    INSTR_VALID && INSTR_OP == OAD_NO_OPERATION_OP
    |=> NO_OPERAND && !X_RD_EN && !Y_RD_EN && !SRC_IS_REG && !BRANCH_EN)
    else $error("no-operation produced an operand");

  chk_pre_modify: assert property (
    INSTR_VALID && INSTR_OP == OAD_GENERIC_OP && SRC_MODE == OAD_AM_PRE
    && DST_MODE == OAD_AM_DIRECT
    |=> SRC_EA == $past(src_base) + $past(step_ext))
    else $error("pre-modify did not use the updated pointer");

  chk_post_modify: assert property (
    INSTR_VALID && INSTR_OP == OAD_GENERIC_OP && SRC_MODE == OAD_AM_POST
    && DST_MODE == OAD_AM_DIRECT && !WREG_WE
    |=> SRC_EA == $past(src_base) && SRC_EA != wreg_r[$past(SRC_REG)]
    || $past(MOD_STEP) == 4'h0)
    else $error("post-modify did not use the old pointer");

endmodule

/* File: verif/oad_xy_mem.sv */
/*
  Behavioural X and Y data memory that counts prefetch reads.
  Assumes one-cycle read enable pulses on the core clock.
*/
`timescale 1ns/1ps
module oad_xy_mem #(
  parameter logic [15:0] Y_BASE = 16'h8000
) (
  input wire logic clk,
  input wire logic x_en,
  input wire logic [15:0] x_addr,
  input wire logic y_en,
  input wire logic [15:0] y_addr,
  output int x_reads,
  output int y_reads,
  output int stray
);
  initial begin
    x_reads = 0;
    y_reads = 0;
    stray = 0;
  end
  // X space below Y_BASE, Y space from it upward
  always @(posedge clk) begin
    if (x_en) x_reads <= x_reads + 1;
    if (y_en) y_reads <= y_reads + 1;
    if ((x_en && x_addr >= Y_BASE) || (y_en && y_addr < Y_BASE)) stray <= stray + 1;
  end
endmodule

/* File: verif/test_operand_address_mode_decode.sv */
/*
  Random self-checking bench of the operand decoder against a register model.
  Assumes the decoder and the X/Y memory model are compiled before it.
*/
`timescale 1ns/1ps
module test_operand_address_mode_decode import oad_pkg::*;;
  logic clk, rst_n, vld, wwe;
  oad_op_t op;
  oad_mode_t sm, dm;
  oad_mac_mode_t xm, ym;
  logic [3:0] sr, dr, ofr, stp, xr, yr, wsel;
  logic [15:0] lit, wdat, rdat, sea, dea, xao, yao, bd;
  logic [13:0] dc;
  logic done, ill, sreg, slit, dreg, xe, ye, be, dsen, imp, no_opnd;
  logic [15:0] w[16];
  int xcnt, ycnt, stray, xexp, yexp;
  int n_fail = 0;
  int checks_done = 0;
  bit [31:0] seed = 12;

  oad_operand_decode i_dut (.REF_CLK(clk), .RESET_N(rst_n), .INSTR_VALID(vld),
    .INSTR_OP(op), .SRC_MODE(sm), .SRC_REG(sr), .DST_MODE(dm), .DST_REG(dr),
    .OFFSET_REGISTER_FIELD(ofr), .MOD_STEP(stp), .LIT_FIELD(lit),
    .X_PREF_REG(xr), .X_PREF_MODE(xm), .Y_PREF_REG(yr), .Y_PREF_MODE(ym),
    .WREG_WE(wwe), .WREG_SEL(wsel), .WREG_WDATA(wdat), .WREG_RDATA(rdat),
    .DEC_DONE(done), .DEC_ILLEGAL(ill), .SRC_EA(sea), .SRC_IS_REG(sreg),
    .SRC_IS_LIT(slit), .DST_EA(dea), .DST_IS_REG(dreg), .X_RD_EN(xe),
    .X_RD_ADDR(xao), .Y_RD_EN(ye), .Y_RD_ADDR(yao), .BRANCH_EN(be),
    .BRANCH_DISP(bd), .INT_DIS_EN(dsen), .INT_DIS_COUNT(dc), .IMPLIED_OP(imp),
    .NO_OPERAND(no_opnd));

  oad_xy_mem i_mem (.clk(clk), .x_en(xe), .x_addr(xao), .y_en(ye), .y_addr(yao),
    .x_reads(xcnt), .y_reads(ycnt), .stray(stray));

  // --------
  // Helpers
  // --------
  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chkb(string nm, logic s, logic e);
    chk(nm, {15'h0000, s}, {15'h0000, e});
  endtask

  task automatic results();
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic logic [15:0] ea(oad_mode_t m, logic [3:0] rg, logic [15:0] st);
    case (m)
      OAD_AM_IND, OAD_AM_POST: return w[rg];
      OAD_AM_PRE: return w[rg] + st;
      OAD_AM_INDEXED: return w[rg] + w[ofr];
      OAD_AM_LIT_OFS: return w[rg] + lit;
      OAD_AM_LIT8: return {8'h00, lit[7:0]};
      OAD_AM_LIT16: return lit;
      default: return 16'h0000;
    endcase
  endfunction

  // --------
  // One random cycle, predicted and compared
  // --------
  task automatic run_one(int k);
    bit [31:0] r1, r2, r3;
    logic [15:0] st, xa, ya, se, de, xn, yn;
    logic [15:0] nw[16];
    bit lg, ok, us, ud, ml, ex, ey, bad;
    int o;
    r1 = rnd();
    r2 = rnd();
    r3 = rnd();
    // Loads of pointers eight to eleven land in their own data space
    if (r3[6:5] == 2'b10) r3[22] = r3[4];
    // Directed cases: valid, no register load, offset register eight
    if (k > 0) begin
      r2[24] = 1'b1;
      r3[0] = 1'b1;
      r1[17:14] = 4'h8;
      r1[24] = 1'b1;
      r2[0] = 1'b1;
    end
    if (k inside {[1:3]}) begin
      r2[31:28] = k == 2 ? 4'h9 : 4'h7;
      r1[28:25] = k == 1 ? 4'h8 : 4'h9;
      r1[31:29] = k == 3 ? 3'h3 : 3'h0;
      r2[4:1] = k == 2 ? 4'hb : 4'ha;
      r2[7:5] = k == 2 ? 3'h4 : 3'h0;
    end
    if (k > 3) begin
      r2[31:28] = k == 6 ? 4'h1 : 4'h3;
      r1[2:0] = k == 4 ? 3'h3 : k == 5 ? 3'h2 : 3'h4;
      r1[5:3] = k == 6 ? 3'h4 : 3'h0;
    end
    sm = oad_mode_t'(r1[2:0]);
    dm = oad_mode_t'(r1[5:3]);
    sr = r1[9:6];
    dr = r1[13:10];
    ofr = r1[17:14];
    stp = r1[21:18];
    xr = r1[24] ? r1[28:25] : {2'b10, r1[23:22]};
    xm = oad_mac_mode_t'(r1[31:29]);
    yr = r2[0] ? r2[4:1] : {2'b10, r2[2:1]};
    ym = oad_mac_mode_t'(r2[7:5]);
    lit = r2[23:8];
    op = oad_op_t'(r2[31:28]);
    wwe = r3[2:0] == 3'h0;
    wsel = r3[6:3];
    wdat = r3[22:7];
    o = int'(r2[31:28]);
    st = {{12{stp[3]}}, stp};
    us = o inside {[1:3]};
    ud = o == 1 || o == 3;
    ml = o inside {[7:10]};
    lg = o == 1 ? dm < 6 : o == 2 ? sm inside {[1:5]} : o == 3 ? sm < 4 && dm < 4
       : ml ? (xr == 9 || (xr == 8 && xm != 4)) && xm < 5
              && (yr == 11 || (yr == 10 && ym != 4)) && ym < 5 : o < 11;
    xa = o == 6 ? w[14] - 16'h0002 : xm == OAD_MAC_INDEXED ? w[xr] + w[ofr] : w[xr];
    ya = ym == OAD_MAC_INDEXED ? w[yr] + w[ofr] : w[yr];
    xn = xm < 4 ? w[xr] + {12'h000, xm, 1'b0} : xa;
    yn = ym < 4 ? w[yr] + {12'h000, ym, 1'b0} : ya;
    // Software never reads outside a pointer's space, before or after stepping
    bad = lg && (o == 6 || ml) && (xa[15] || ml && (xn[15] || !ya[15] || !yn[15]));
    vld = r2[26:24] != 3'h0 && !bad;
    ok = vld && lg;
    ex = ok && (ml || o == 6);
    ey = ok && ml;
    se = us && ok ? ea(sm, sr, st) : 16'h0000;
    de = ud && ok ? ea(dm, dr, st) : 16'h0000;
    nw = w;
    if (wwe) nw[wsel] = wdat;
    if (ok && us && sm inside {OAD_AM_POST, OAD_AM_PRE}) nw[sr] = w[sr] + st;
    if (ok && ud && dm inside {OAD_AM_POST, OAD_AM_PRE}) nw[dr] = w[dr] + st;
    if (ey && xm inside {[1:3]}) nw[xr] = w[xr] + {12'h000, xm, 1'b0};
    if (ey && ym inside {[1:3]}) nw[yr] = w[yr] + {12'h000, ym, 1'b0};
    if (ok && o == 6) nw[15] = w[14] - 16'h0002;
    @(posedge clk);
    @(negedge clk);
    w = nw;
    chkb("done", done, vld);
    chkb("illegal", ill, vld && !lg);
    if (vld) begin
      if (!(ok && us && sm == OAD_AM_DIRECT)) chk("src ea", sea, se);
      if (!(ok && ud && dm == OAD_AM_DIRECT)) chk("dst ea", dea, de);
      chkb("src reg", sreg, ok && us && sm == OAD_AM_DIRECT);
      chkb("src lit", slit, ok && us && sm > 5);
      chkb("dst reg", dreg, ok && ud && dm == OAD_AM_DIRECT);
    end
    chkb("x read", xe, ex);
    chkb("y read", ye, ey);
    if (ex) chk("x addr", xao, xa);
    if (ey) chk("y addr", yao, ya);
    chkb("branch", be, ok && o == 4);
    if (ok && o == 4) chk("disp", bd, lit);
    chkb("disable", dsen, ok && o == 5);
    if (ok && o == 5) chk("count", {2'b00, dc}, {2'b00, lit[13:0]});
    chkb("implied", imp, ok && o == 6);
    chkb("no operand", no_opnd, ok && o == 0);
    xexp += int'(ex);
    yexp += int'(ey);
  endtask

  // --------
  // Clock, watchdog and main sequence
  // --------
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end

  initial begin
    rst_n = 0;
    vld = 0;
    wwe = 0;
    op = OAD_NO_OPERATION_OP;
    sm = OAD_AM_DIRECT;
    dm = OAD_AM_DIRECT;
    xm = OAD_MAC_IND;
    ym = OAD_MAC_IND;
    {sr, dr, ofr, stp, xr, yr, wsel} = 28'h0;
    lit = 16'h0000;
    wdat = 16'h0000;
    xexp = 0;
    yexp = 0;
    foreach (w[i]) w[i] = 16'h0000;
    repeat (20) @(negedge clk);
    chkb("reset done", done, 1'b0);
    chk("reset rdata", rdat, 16'h0000);
    rst_n = 1;
    for (int i = 0; i < 16; i++) begin
      wwe = 1;
      wsel = 4'(i);
      wdat = i inside {[8:11]} ? {i[1], 3'h0, 12'(rnd())} : 16'(rnd());
      w[i] = wdat;
      @(negedge clk);
    end
    wwe = 0;
    for (int k = 1; k <= 6; k++) run_one(k);
    repeat (3000) run_one(0);
    vld = 0;
    wwe = 0;
    for (int i = 0; i < 16; i++) begin
      wsel = 4'(i);
      repeat (2) @(negedge clk);
      chk("wreg", rdat, w[i]);
    end
    chk("x reads", 16'(xcnt), 16'(xexp));
    chk("y reads", 16'(ycnt), 16'(yexp));
    chk("stray", 16'(stray), 16'h0000);
    results();
  end
endmodule
